// >>> hdl/sacb_pkg.sv
package sacb_pkg;

  // ----------------------------------------------------------------
  // register map (printed offsets are indices; byte address = 4 x index)
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_CFG_IDX = 8'h82;
  localparam logic [7:0] FRONTEND_CFG_IDX = 8'h83;
  localparam logic [7:0] OFFSET_HIGH_IDX = 8'h84;
  localparam logic [7:0] OFFSET_LOW_IDX = 8'h85;
  localparam logic [7:0] RESULT_IDX = 8'h86;
  localparam logic [7:0] STATUS_IDX = 8'h87;
  localparam logic [7:0] CONTROL_IDX = 8'h88;

  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [15:0] MODE_CFG_RST = 16'h0400;
  localparam logic [15:0] FRONTEND_CFG_RST = 16'h8010;
  localparam logic [15:0] OFFSET_HIGH_RST = 16'h0000;
  localparam logic [15:0] OFFSET_LOW_RST = 16'h0000;
  localparam logic [15:0] MODE_CFG_MASK = 16'h0F0F;
  localparam logic [15:0] FRONTEND_CFG_MASK = 16'h8F3F;
  localparam logic [15:0] OFFSET_LOW_MASK = 16'hFF00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CONV_KIND_BIT = 11;
  localparam int OSR_LSB = 8;
  localparam int GC_EN_BIT = 3;
  localparam int GC_DELAY_LSB = 0;
  localparam int CH_EN_BIT = 15;
  localparam int GAIN_LSB = 10;
  localparam int ROUTE_LSB = 8;
  localparam int SRC_ROUTE_BIT = 5;
  localparam int SINK_ROUTE_BIT = 4;
  localparam int SRC_MAG_LSB = 2;
  localparam int SINK_MAG_LSB = 0;

  // ----------------------------------------------------------------
  // encodings and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] ROUTE_NORMAL = 2'h0;
  localparam logic [1:0] ROUTE_SWAPPED = 2'h1;
  localparam logic [1:0] ROUTE_SHORT = 2'h2;
  localparam logic [1:0] ROUTE_TEST_DAC = 2'h3;
  localparam logic [1:0] ANALOG_GAIN_MAX_CODE = 2'h1;
  localparam int OSR_BASE_LOG2 = 6;
  localparam int GC_DELAY_BASE_LOG2 = 1;
  localparam int CNT_W = 14;
  localparam logic [1:0] BUS_WAIT_CYCLES = 2'h1;

  typedef struct packed {
    logic conv_kind;
    logic [2:0] osr_code;
    logic gc_en;
    logic [2:0] gc_delay;
  } sacb_mode_s;

  typedef struct packed {
    logic ch_en;
    logic [1:0] gain_code;
    logic [1:0] route;
    logic src_route;
    logic sink_route;
    logic [1:0] src_mag;
    logic [1:0] sink_mag;
  } sacb_front_s;

endpackage

// >>> hdl/sacb_bank.sv
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
module sacb_bank (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic modulator_tick,
  input wire logic [23:0] raw_result,
  input wire logic raw_valid,
  input wire logic standby_pin,
  output logic [23:0] result_r,
  output logic result_valid_r,
  output logic [1:0] conversion_tally_r,
  output logic conv_kind_r,
  output logic chop_phase_r,
  output logic analog_gain_x8_r,
  output logic [1:0] digital_shift_r,
  output logic [1:0] input_route_r,
  output logic test_source_route_r,
  output logic test_sink_route_r,
  output logic [1:0] test_source_magnitude_r,
  output logic [1:0] test_sink_magnitude_r
);

  // ----------------------------------------------------------------
  // registers and helpers
  // ----------------------------------------------------------------
  logic [15:0] mode_r;
  logic [15:0] front_r;
  logic [15:0] ofs_hi_r;
  logic [15:0] ofs_lo_r;
  logic start_r;
  logic busy_r;
  logic gc_settle_r;
  localparam int CNT_W_L = sacb_pkg::CNT_W;

  logic [CNT_W_L-1:0] tick_cnt_r;
  logic [8:0] gc_cnt_r;
  logic [1:0] standby_s1_r;
  logic standby_r;
  logic [1:0] wait_r;
  logic access;
  logic [7:0] idx;
  logic idx_ok;
  logic [15:0] wdat;
  logic [15:0] rd_word;
  logic ch_on;
  sacb_pkg::sacb_mode_s mode_f;
  sacb_pkg::sacb_front_s front_f;
  logic [23:0] trim;
  logic [23:0] scaled;
  logic answer;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [3:0] be, input logic [15:0] msk);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & msk;
    merge16 = (old & ~m) | (nw & m);
  endfunction

  // oversample ratio as a count of modulator ticks
  function automatic logic [CNT_W_L-1:0] osr_ticks(input logic [2:0] code);
    osr_ticks = CNT_W_L'(1) << ({1'b0, code} + 4'(sacb_pkg::OSR_BASE_LOG2));
  endfunction

  assign mode_f = sacb_pkg::sacb_mode_s'({mode_r[11:8], mode_r[3:0]});
  assign front_f = sacb_pkg::sacb_front_s'({front_r[15], front_r[11:8], front_r[5:0]});
  // offset trim assembly
  // high word bits above bits 15:8 of the low register
  assign trim = {ofs_hi_r, ofs_lo_r[15:8]};
  assign ch_on = front_f.ch_en && !standby_r;
  assign access = (avs_read || avs_write) && wait_r == sacb_pkg::BUS_WAIT_CYCLES;
  // read data must already stand when the master sees waitrequest low
  assign answer = (avs_read || avs_write) && wait_r == sacb_pkg::BUS_WAIT_CYCLES - 2'h1;
  assign idx = avs_address[9:2];
  assign idx_ok = idx >= sacb_pkg::MODE_CFG_IDX && idx <= sacb_pkg::CONTROL_IDX;
  assign wdat = avs_writedata[15:0];

  // ----------------------------------------------------------------
  // standby pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      standby_s1_r <= 2'h0;
      standby_r <= 1'b0;
    end else if (clk_en) begin
      standby_s1_r <= {standby_s1_r[0], standby_pin};
      standby_r <= standby_s1_r[1];
    end
  end

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_r <= 2'h0;
    end else if (clk_en) begin
      if ((avs_read || avs_write) && wait_r != sacb_pkg::BUS_WAIT_CYCLES) begin
        wait_r <= wait_r + 2'h1;
      end else begin
        wait_r <= 2'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest <= !answer;
    end
  end

  always_comb begin
    rd_word = 16'h0000;
    case (idx)
      sacb_pkg::MODE_CFG_IDX: rd_word = mode_r;
      sacb_pkg::FRONTEND_CFG_IDX: rd_word = front_r;
      sacb_pkg::OFFSET_HIGH_IDX: rd_word = ofs_hi_r;
      sacb_pkg::OFFSET_LOW_IDX: rd_word = ofs_lo_r;
      sacb_pkg::RESULT_IDX: rd_word = result_r[23:8];
      sacb_pkg::STATUS_IDX: rd_word = {12'h000, busy_r, gc_settle_r, conversion_tally_r};
      default: rd_word = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
      avs_response <= 2'h0;
    end else if (clk_en && answer) begin
      avs_readdata <= avs_read ? {16'h0000, rd_word} : 32'h00000000;
      avs_response <= idx_ok ? 2'h0 : 2'h3;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_r <= sacb_pkg::MODE_CFG_RST;
      front_r <= sacb_pkg::FRONTEND_CFG_RST;
      ofs_hi_r <= sacb_pkg::OFFSET_HIGH_RST;
      ofs_lo_r <= sacb_pkg::OFFSET_LOW_RST;
    end else if (clk_en && access && avs_write) begin
      case (idx)
        sacb_pkg::MODE_CFG_IDX:
          mode_r <= merge16(mode_r, wdat, avs_byteenable, sacb_pkg::MODE_CFG_MASK);
        sacb_pkg::FRONTEND_CFG_IDX:
          front_r <= merge16(front_r, wdat, avs_byteenable, sacb_pkg::FRONTEND_CFG_MASK);
        sacb_pkg::OFFSET_HIGH_IDX:
          ofs_hi_r <= merge16(ofs_hi_r, wdat, avs_byteenable, 16'hFFFF);
        sacb_pkg::OFFSET_LOW_IDX:
          ofs_lo_r <= merge16(ofs_lo_r, wdat, avs_byteenable, sacb_pkg::OFFSET_LOW_MASK);
        default: ;
      endcase
    end
  end

  // single-shot start request from control register bit 0
  always_ff @(posedge clk) begin
    if (reset) begin
      start_r <= 1'b0;
    end else if (clk_en) begin
      start_r <= access && avs_write && idx == sacb_pkg::CONTROL_IDX &&
                 avs_byteenable[0] && wdat[0];
    end
  end

  // ----------------------------------------------------------------
  // front-end steering outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      conv_kind_r <= 1'b0;
      analog_gain_x8_r <= 1'b0;
      digital_shift_r <= 2'h0;
      input_route_r <= sacb_pkg::ROUTE_NORMAL;
      test_source_route_r <= 1'b0;
      test_sink_route_r <= 1'b1;
      test_source_magnitude_r <= 2'h0;
      test_sink_magnitude_r <= 2'h0;
    end else if (clk_en) begin
      conv_kind_r <= mode_f.conv_kind;
      analog_gain_x8_r <= front_f.gain_code != 2'h0;
      digital_shift_r <= (front_f.gain_code > sacb_pkg::ANALOG_GAIN_MAX_CODE) ?
                         front_f.gain_code - sacb_pkg::ANALOG_GAIN_MAX_CODE : 2'h0;
      input_route_r <= front_f.route;
      test_source_route_r <= front_f.src_route;
      test_sink_route_r <= front_f.sink_route;
      test_source_magnitude_r <= front_f.src_mag;
      test_sink_magnitude_r <= front_f.sink_mag;
    end
  end

  // ----------------------------------------------------------------
  // conversion timing
  // ----------------------------------------------------------------
  // one result per osr ticks
  always_ff @(posedge clk) begin
    if (reset) begin
      tick_cnt_r <= '0;
      busy_r <= 1'b0;
    end else if (clk_en) begin
      if (!ch_on) begin
        tick_cnt_r <= '0;
        busy_r <= 1'b0;
      end else if (mode_f.conv_kind && !busy_r) begin
        busy_r <= start_r;
        tick_cnt_r <= '0;
      end else if (modulator_tick && !gc_settle_r) begin
        if (tick_cnt_r >= osr_ticks(mode_f.osr_code) - CNT_W_L'(1)) begin
          tick_cnt_r <= '0;
          busy_r <= 1'b0;
        end else begin
          tick_cnt_r <= tick_cnt_r + CNT_W_L'(1);
        end
      end
    end
  end

  // settle delay after each phase flip
  always_ff @(posedge clk) begin
    if (reset) begin
      chop_phase_r <= 1'b0;
      gc_settle_r <= 1'b0;
      gc_cnt_r <= 9'h000;
    end else if (clk_en) begin
      if (!ch_on || !mode_f.gc_en) begin
        chop_phase_r <= 1'b0;
        gc_settle_r <= 1'b0;
        gc_cnt_r <= 9'h000;
      end else if (gc_settle_r) begin
        if (modulator_tick) begin
          if (gc_cnt_r >= (9'h001 << ({1'b0, mode_f.gc_delay} +
              4'(sacb_pkg::GC_DELAY_BASE_LOG2))) - 9'h001) begin
            gc_settle_r <= 1'b0;
            gc_cnt_r <= 9'h000;
          end else begin
            gc_cnt_r <= gc_cnt_r + 9'h001;
          end
        end
      end else if (raw_valid) begin
        chop_phase_r <= !chop_phase_r;
        gc_settle_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // result path
  // ----------------------------------------------------------------
  assign scaled = raw_result << digital_shift_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      result_r <= 24'h000000;
      result_valid_r <= 1'b0;
      conversion_tally_r <= 2'h0;
    end else if (clk_en) begin
      result_valid_r <= 1'b0;
      if (!ch_on) begin
        result_r <= 24'h000000;
        conversion_tally_r <= 2'h0;
      end else if (raw_valid && !gc_settle_r) begin
        result_r <= scaled - trim;
        result_valid_r <= 1'b1;
        conversion_tally_r <= conversion_tally_r + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  mode_reset_a: assert property (@(posedge clk) $fell(reset) |->
    mode_r == 16'h0400) else $error("mode reset value wrong");
  front_reset_a: assert property (@(posedge clk) $fell(reset) |->
    front_r == 16'h8010) else $error("front-end reset value wrong");
  disable_clear_a: assert property (@(posedge clk) disable iff (reset)
    clk_en && !ch_on |=> result_r == 24'h0 && conversion_tally_r == 2'h0)
    else $error("result not cleared on disable");
  reserved_zero_a: assert property (@(posedge clk) disable iff (reset)
    (mode_r & 16'hF0F0) == 16'h0 && (ofs_lo_r[7:0] == 8'h00) && (front_r & 16'h70C0) == 16'h0)
    else $error("reserved bit set");
  offset_sub_a: assert property (@(posedge clk) disable iff (reset)
    clk_en && ch_on && raw_valid && !gc_settle_r |=>
    result_r == $past(scaled) - $past(trim)) else $error("offset not subtracted");
  gain_digital_a: assert property (@(posedge clk) disable iff (reset)
    clk_en ##1 front_f.gain_code == $past(front_f.gain_code) && front_f.gain_code == 2'h3
    |-> digital_shift_r == 2'h2) else $error("gain 32 shift wrong");
  route_follow_a: assert property (@(posedge clk) disable iff (reset)
    clk_en |=> input_route_r == $past(front_r[9:8])) else $error("route not applied");
  sink_route_a: assert property (@(posedge clk) disable iff (reset)
    clk_en |=> test_sink_route_r == $past(front_r[4])) else $error("sink route wrong");
  tally_step_a: assert property (@(posedge clk) disable iff (reset)
    result_valid_r && $past(clk_en) |-> conversion_tally_r == $past(conversion_tally_r) + 2'h1)
    else $error("tally did not advance");
  freeze_hold_a: assert property (@(posedge clk) disable iff (reset)
    !clk_en |=> $stable(result_r) && $stable(conversion_tally_r))
    else $error("result moved while frozen");
  shift_low_a: assert property (@(posedge clk) disable iff (reset)
    clk_en && front_f.gain_code <= 2'h1 |=> digital_shift_r == 2'h0)
    else $error("analog gain given a digital shift");
  chop_idle_a: assert property (@(posedge clk) disable iff (reset)
    clk_en && !ch_on |=> !gc_settle_r && !chop_phase_r)
    else $error("chop active on idle channel");
  osr_hold_a: assert property (@(posedge clk) disable iff (reset)
    clk_en && ch_on && busy_r && !gc_settle_r && mode_f.osr_code == 3'h2 &&
    tick_cnt_r < 14'h00FF |=> busy_r) else $error("conversion ended early");
  osr_end_a: assert property (@(posedge clk) disable iff (reset)
    clk_en && ch_on && busy_r && !gc_settle_r && modulator_tick &&
    mode_f.osr_code == 3'h2 && tick_cnt_r == 14'h00FF |=> !busy_r)
    else $error("conversion overran its ratio");
  chop_delay_a: assert property (@(posedge clk) disable iff (reset)
    clk_en && ch_on && mode_f.gc_en && gc_settle_r && mode_f.gc_delay == 3'h7 &&
    gc_cnt_r != 9'h0FF |=> gc_settle_r) else $error("chop delay cut short");
  bus_answer_a: assert property (@(posedge clk) disable iff (reset)
    clk_en && $rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("bus answer late");

endmodule

// >>> verification/tb_shunt_adc_a_config_bank.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end

module tb_shunt_adc_a_config_bank;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'h3;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic modulator_tick = 1'b0;
  logic [23:0] raw_result = 24'h000000;
  logic raw_valid = 1'b0;
  logic standby_pin = 1'b0;
  logic [23:0] result_r;
  logic result_valid_r, conv_kind_r, chop_phase_r, analog_gain_x8_r;
  logic [1:0] conversion_tally_r, digital_shift_r, input_route_r;
  logic test_source_route_r, test_sink_route_r;
  logic [1:0] test_source_magnitude_r, test_sink_magnitude_r;
  int n_errors = 0;
  int n_tests = 0;
  logic [1:0] tick_cnt = 2'h0;
  logic [15:0] lf = 16'h003F;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [15:0] mv, fv, oh, ol;
  logic [23:0] raw, exp_r;
  logic p;
  logic [15:0] mc [4] = '{16'h0FFF, 16'h0000, 16'hFB0B, 16'h0708};
  logic [15:0] fc [4] = '{16'hFFFF, 16'h0000, 16'h8A15, 16'h052A};

  sacb_bank i_sacb_bank (
    .clk(clk), .reset(reset), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .modulator_tick(modulator_tick), .raw_result(raw_result), .raw_valid(raw_valid),
    .standby_pin(standby_pin), .result_r(result_r), .result_valid_r(result_valid_r),
    .conversion_tally_r(conversion_tally_r), .conv_kind_r(conv_kind_r),
    .chop_phase_r(chop_phase_r), .analog_gain_x8_r(analog_gain_x8_r),
    .digital_shift_r(digital_shift_r), .input_route_r(input_route_r),
    .test_source_route_r(test_source_route_r), .test_sink_route_r(test_sink_route_r),
    .test_source_magnitude_r(test_source_magnitude_r),
    .test_sink_magnitude_r(test_sink_magnitude_r)
  );

  // ----------------------------------------------------------------
  // clock, modulator tick, watchdog
  // ----------------------------------------------------------------
  always #4 clk = ~clk;

  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    modulator_tick <= (tick_cnt == 2'h3);
  end

  initial begin
    #(8 * 20000);
    n_errors++;
    test_done();
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [1:0] exp_shift(input logic [1:0] g);
    return (g == 2'h3) ? 2'h2 : ((g == 2'h2) ? 2'h1 : 2'h0);
  endfunction

  function automatic int osr_of(input int c);
    return 64 << c;
  endfunction

  function automatic int gcd_of(input int c);
    return 2 << c;
  endfunction

  task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {idx, 2'h0};
    avs_writedata <= {16'h0000, d};
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 64) begin
      n_errors++;
      $display("wrong value at %0t: bus answer missing", $time);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [15:0] e);
    bus(1'b0, idx, 16'h0000);
    `CHK(rd, {16'h0000, e})
    `CHK(rsp, 2'h0)
  endtask

  task automatic pulse(input logic [23:0] r);
    @(posedge clk);
    raw_result <= r;
    raw_valid <= 1'b1;
    @(posedge clk);
    raw_valid <= 1'b0;
    #1;
  endtask

  task automatic conv(input logic [23:0] r);
    int n;
    n = 0;
    pulse(r);
    while (result_valid_r !== 1'b1 && n < 64) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(result_valid_r, 1'b1)
  endtask

  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    #1;
    `CHK(test_sink_route_r, 1'b1)
    `CHK(conv_kind_r, 1'b0)
    `CHK(result_r, 24'h000000)
    rd_chk(sacb_pkg::MODE_CFG_IDX, 16'h0400);
    rd_chk(sacb_pkg::FRONTEND_CFG_IDX, 16'h8010);
    rd_chk(sacb_pkg::OFFSET_HIGH_IDX, 16'h0000);
    rd_chk(sacb_pkg::OFFSET_LOW_IDX, 16'h0000);
    // unmapped place answers with an error and changes nothing
    wr(8'h90, 16'hFFFF);
    `CHK(rsp, 2'h3)
    bus(1'b0, 8'h90, 16'h0000);
    `CHK({rsp, rd}, {2'h3, 32'h00000000})
    rd_chk(sacb_pkg::MODE_CFG_IDX, 16'h0400);
    // corner then random configurations; the corners give every code of every front-end field
    for (int i = 0; i < 12; i++) begin
      lf = lfsr_next(lf);
      mv = (i < 4) ? mc[i] : lf;
      lf = lfsr_next(lf);
      fv = (i < 4) ? fc[i] : lf;
      wr(sacb_pkg::MODE_CFG_IDX, mv);
      wr(sacb_pkg::FRONTEND_CFG_IDX, fv);
      rd_chk(sacb_pkg::MODE_CFG_IDX, mv & 16'h0F0F);
      rd_chk(sacb_pkg::FRONTEND_CFG_IDX, fv & 16'h8F3F);
      `CHK(conv_kind_r, mv[11])
      `CHK(analog_gain_x8_r, fv[11:10] != 2'h0)
      `CHK(digital_shift_r, exp_shift(fv[11:10]))
      `CHK(input_route_r, fv[9:8])
      `CHK(test_source_route_r, fv[5])
      `CHK(test_sink_route_r, fv[4])
      `CHK(test_source_magnitude_r, fv[3:2])
      `CHK(test_sink_magnitude_r, fv[1:0])
    end
    // offset trim split over two registers and subtracted per result
    lf = lfsr_next(lf);
    oh = lf;
    lf = lfsr_next(lf);
    ol = lf;
    wr(sacb_pkg::OFFSET_HIGH_IDX, oh);
    wr(sacb_pkg::OFFSET_LOW_IDX, ol);
    rd_chk(sacb_pkg::OFFSET_HIGH_IDX, oh);
    rd_chk(sacb_pkg::OFFSET_LOW_IDX, ol & 16'hFF00);
    wr(sacb_pkg::MODE_CFG_IDX, 16'h0000);
    wr(sacb_pkg::FRONTEND_CFG_IDX, 16'h8010);
    for (int k = 0; k < 3; k++) begin
      lf = lfsr_next(lf);
      raw = {lf, lf[15:8] ^ 8'hA5};
      conv(raw);
      exp_r = raw - {oh, ol[15:8]};
      `CHK(result_r, exp_r)
      rd_chk(sacb_pkg::RESULT_IDX, exp_r[23:8]);
      oh = oh ^ 16'h8001;
      ol = {ol[7:0], ol[15:8]};
      wr(sacb_pkg::OFFSET_HIGH_IDX, oh);
      wr(sacb_pkg::OFFSET_LOW_IDX, ol);
    end
    // a frozen clock enable ignores a raw value
    clk_en <= 1'b0;
    pulse(24'h000100);
    `CHK(result_valid_r, 1'b0)
    `CHK(result_r, exp_r)
    clk_en <= 1'b1;
    // disabling the channel clears result and tally
    wr(sacb_pkg::FRONTEND_CFG_IDX, 16'h0010);
    repeat (2) @(posedge clk);
    #1;
    `CHK({result_r, conversion_tally_r}, 26'h0000000)
    wr(sacb_pkg::FRONTEND_CFG_IDX, 16'h8010);
    conv(24'h7FFFFF);
    `CHK(conversion_tally_r, 2'h1)
    @(posedge clk);
    standby_pin <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    `CHK({result_r, conversion_tally_r}, 26'h0000000)
    @(posedge clk);
    standby_pin <= 1'b0;
    // single-shot at ratio 256: busy for that many modulator ticks
    wr(sacb_pkg::MODE_CFG_IDX, 16'h0A00);
    wr(sacb_pkg::CONTROL_IDX, 16'h0001);
    bus(1'b0, sacb_pkg::STATUS_IDX, 16'h0000);
    `CHK(rd[3], 1'b1)
    repeat (4 * osr_of(2) - 40) @(posedge clk);
    bus(1'b0, sacb_pkg::STATUS_IDX, 16'h0000);
    `CHK(rd[3], 1'b1)
    repeat (60) @(posedge clk);
    bus(1'b0, sacb_pkg::STATUS_IDX, 16'h0000);
    `CHK(rd[3], 1'b0)
    // chop enabled: a conversion flips the chop phase, then settles 256 ticks
    wr(sacb_pkg::MODE_CFG_IDX, 16'h080F);
    p = chop_phase_r;
    pulse(24'h123456);
    repeat (3) @(posedge clk);
    #1;
    `CHK(chop_phase_r, ~p)
    `CHK(conv_kind_r, 1'b1)
    repeat (4 * gcd_of(7) - 60) @(posedge clk);
    bus(1'b0, sacb_pkg::STATUS_IDX, 16'h0000);
    `CHK(rd[2], 1'b1)
    repeat (80) @(posedge clk);
    bus(1'b0, sacb_pkg::STATUS_IDX, 16'h0000);
    `CHK(rd[2], 1'b0)
    test_done();
  end
endmodule
